// *** dtc_cfg.svh ***
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// register offsets on the plain register port
`define DTC_OFS_MODE      3'h0
`define DTC_OFS_CTRL      3'h1
`define DTC_OFS_CLK       3'h2
`define DTC_OFS_U0_LO     3'h3
`define DTC_OFS_U0_HI     3'h4
`define DTC_OFS_U1_LO     3'h5
`define DTC_OFS_U1_HI     3'h6

// timer_mode_reg fields
`define DTC_U0_MODE_LSB   0
`define DTC_U0_CT_BIT     2
`define DTC_U0_GATE_BIT   3
`define DTC_U1_MODE_LSB   4
`define DTC_U1_CT_BIT     6
`define DTC_U1_GATE_BIT   7

// timer_ctrl_reg fields
`define DTC_RUN0_BIT      4
`define DTC_FLAG0_BIT     5
`define DTC_RUN1_BIT      6
`define DTC_FLAG1_BIT     7

// clock_ctrl_reg fields
`define DTC_SPD0_BIT      3
`define DTC_SPD1_BIT      4

// reset values
`define DTC_RST_BYTE      8'h00
`define DTC_RST_BIT       1'b0

// machine cycles per slow tick, less one (1/12 rate = 3 machine cycles of 4 clocks)
`define DTC_DIV12_LAST    2'h2

`endif

// *** dtc_pin_sync.sv ***
`timescale 1ns/10ps
module dtc_pin_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // raw pin and its filtered level
  input  wire logic pin,
  output logic      level
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change is accepted once the last two stages agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end

endmodule

// *** dtc_pkg.sv ***
package dtc_pkg;

  typedef logic [2:0] dtc_addr_t;
  typedef logic [7:0] dtc_byte_t;

  // machine-cycle phases, one system clock each
  typedef enum logic [1:0] {
    PH_C1,
    PH_C2,
    PH_C3,
    PH_C4
  } dtc_phase_e;

  typedef enum logic [1:0] {
    MODE_13,
    MODE_16,
    MODE_RELOAD,
    MODE_SPLIT
  } dtc_mode_e;

endpackage

// *** dtc_pulse_src.sv ***
`timescale 1ns/10ps
module dtc_pulse_src (
  // clock
  input  wire logic mclk,
  // pins toward the timer pair
  output logic      count_input_a,
  output logic      count_input_b,
  output logic      ext_irq_pin_a,
  output logic      ext_irq_pin_b
);
  // pins idle high so that no falling edge is seen at start
  initial begin
    count_input_a = 1'b1;
    count_input_b = 1'b1;
    ext_irq_pin_a = 1'b1;
    ext_irq_pin_b = 1'b1;
  end

  task automatic put(input logic unit, input logic lvl);
    if (unit) begin
      count_input_b <= lvl;
    end else begin
      count_input_a <= lvl;
    end
  endtask

  // each level stands hold clocks; hold of 4 or more keeps one machine cycle
  task automatic pulses(input logic unit, input int n, input int hold);
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      put(unit, 1'b0);
      repeat (hold) @(posedge mclk);
      put(unit, 1'b1);
      repeat (hold) @(posedge mclk);
    end
  endtask

  task automatic gate(input logic unit, input logic lvl);
    @(posedge mclk);
    if (unit) begin
      ext_irq_pin_b <= lvl;
    end else begin
      ext_irq_pin_a <= lvl;
    end
  endtask
endmodule

// *** dtc_timer_pair.sv ***
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "dtc_cfg.svh"
// Function
// - timer ticks at one twelfth or one quarter
// - count pin sampled at C4, high-then-low edge
// - count register updates at C3, next machine cycle
// - function select bits 2 and 6
// - two-bit mode field per unit
// - count only when run and gate allow, save the high byte and unit 1 under split
// - mode 0 is 13-bit, low byte five bits
// - mode 0 wrap sets overflow flag
// - mode 1 uses full 16 bits
// - timer counts on mclk rising edge closing C3
// - mode 2 reloads low byte from high
// - mode 3 low byte keeps unit 0 controls
// - mode 3 high byte uses unit 1 run, flag
// - unit 1 mode 3 freezes unit 1
// - unit 1 under split: ticks only, no flag
// - flag set by overflow, cleared on vector
module dtc_timer_pair (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // register port
  input  wire dtc_pkg::dtc_addr_t reg_addr,
  input  wire dtc_pkg::dtc_byte_t reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output dtc_pkg::dtc_byte_t     reg_rdata,
  // external pins
  input  wire logic              count_input_a,
  input  wire logic              count_input_b,
  input  wire logic              ext_irq_pin_a,
  input  wire logic              ext_irq_pin_b,
  // interrupt controller side
  input  wire logic              unit0_vector_ack,
  input  wire logic              unit1_vector_ack,
  output logic                   unit0_overflow_flag,
  output logic                   unit1_overflow_flag
);
  import dtc_pkg::*;

  dtc_byte_t  timer_mode_reg;
  logic       unit0_run_bit;
  logic       unit1_run_bit;
  logic       unit0_speed_sel;
  logic       unit1_speed_sel;
  dtc_byte_t  unit0_low_byte;
  dtc_byte_t  unit0_high_byte;
  dtc_byte_t  unit1_low_byte;
  dtc_byte_t  unit1_high_byte;
  dtc_phase_e phase;
  logic [1:0] mc_div;
  logic       lvl_a;
  logic       lvl_b;
  logic       irq_lvl_a;
  logic       irq_lvl_b;
  logic       smp_a;
  logic       smp_b;
  logic       pend_a;
  logic       pend_b;

  function automatic logic rate_tick(input logic speed, input logic [1:0] div);
    return speed | (div == `DTC_DIV12_LAST);
  endfunction

  // one count step: {overflow, high, low}
  function automatic logic [16:0] step(input dtc_mode_e m, input dtc_byte_t hi,
                                       input dtc_byte_t lo);
    logic [12:0] v13;
    logic [15:0] v16;
    v13 = 13'({hi, lo[4:0]} + 13'h0001);
    v16 = 16'({hi, lo} + 16'h0001);
    unique case (m)
      MODE_13:     return {({hi, lo[4:0]} == 13'h1FFF), v13[12:5], lo[7:5], v13[4:0]};
      MODE_16:     return {({hi, lo} == 16'hFFFF), v16};
      MODE_RELOAD: return (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, 8'(lo + 8'h01)};
      MODE_SPLIT:  return {(lo == 8'hFF), hi, 8'(lo + 8'h01)};
    endcase
  endfunction

  dtc_pin_sync u_sync_cnt_a (.mclk(mclk), .sys_rst(sys_rst), .pin(count_input_a), .level(lvl_a));
  dtc_pin_sync u_sync_cnt_b (.mclk(mclk), .sys_rst(sys_rst), .pin(count_input_b), .level(lvl_b));
  dtc_pin_sync u_sync_irq_a (.mclk(mclk), .sys_rst(sys_rst), .pin(ext_irq_pin_a),
                             .level(irq_lvl_a));
  dtc_pin_sync u_sync_irq_b (.mclk(mclk), .sys_rst(sys_rst), .pin(ext_irq_pin_b),
                             .level(irq_lvl_b));

  // field decode
  dtc_mode_e mode0;
  dtc_mode_e mode1;
  logic      ct0;
  logic      ct1;
  logic      gate0;
  logic      gate1;
  assign mode0 = dtc_mode_e'(timer_mode_reg[`DTC_U0_MODE_LSB +: 2]);
  assign mode1 = dtc_mode_e'(timer_mode_reg[`DTC_U1_MODE_LSB +: 2]);
  assign ct0   = timer_mode_reg[`DTC_U0_CT_BIT];
  assign ct1   = timer_mode_reg[`DTC_U1_CT_BIT];
  assign gate0 = timer_mode_reg[`DTC_U0_GATE_BIT];
  assign gate1 = timer_mode_reg[`DTC_U1_GATE_BIT];

  // machine-cycle phase and slow-rate divider
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase <= PH_C1;
    end else begin
      unique case (phase)
        PH_C1: phase <= PH_C2;
        PH_C2: phase <= PH_C3;
        PH_C3: phase <= PH_C4;
        PH_C4: phase <= PH_C1;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mc_div <= 2'h0;
    end else if (phase == PH_C4) begin
      mc_div <= (mc_div == `DTC_DIV12_LAST) ? 2'h0 : 2'(mc_div + 2'h1);
    end
  end

  // count pins sampled once per machine cycle; an edge waits for the next C3
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      smp_a  <= 1'b0;
      smp_b  <= 1'b0;
      pend_a <= 1'b0;
      pend_b <= 1'b0;
    end else if (phase == PH_C4) begin
      smp_a  <= lvl_a;
      smp_b  <= lvl_b;
      pend_a <= smp_a & ~lvl_a;
      pend_b <= smp_b & ~lvl_b;
    end
  end

  // count events, all landing in C3
  logic at_c3;
  logic run0_ok;
  logic run1_ok;
  logic split0;
  logic frozen1;
  logic ev0;
  logic ev1;
  logic hi0_ev;
  assign at_c3   = (phase == PH_C3);
  assign run0_ok = unit0_run_bit && (!gate0 || irq_lvl_a);
  assign run1_ok = unit1_run_bit && (!gate1 || irq_lvl_b);
  assign split0  = (mode0 == MODE_SPLIT);
  assign frozen1 = (mode1 == MODE_SPLIT);
  assign ev0     = at_c3 && run0_ok
                   && (ct0 ? pend_a : rate_tick(unit0_speed_sel, mc_div));
  assign hi0_ev  = at_c3 && split0 && unit1_run_bit
                   && rate_tick(unit0_speed_sel, mc_div);
  assign ev1     = !frozen1 && at_c3 && (split0 ? rate_tick(unit1_speed_sel, mc_div)
                                                : run1_ok && (ct1 ? pend_b
                                                   : rate_tick(unit1_speed_sel, mc_div)));

  logic [16:0] nxt0;
  logic [16:0] nxt1;
  logic        ovf0;
  logic        ovf_hi0;
  logic        ovf1;
  assign nxt0    = step(mode0, unit0_high_byte, unit0_low_byte);
  assign nxt1    = step(mode1, unit1_high_byte, unit1_low_byte);
  assign ovf0    = ev0 && nxt0[16];
  assign ovf_hi0 = hi0_ev && (unit0_high_byte == 8'hFF);
  assign ovf1    = ev1 && nxt1[16] && !split0;

  logic wr_ctrl;
  assign wr_ctrl = reg_wr && (reg_addr == `DTC_OFS_CTRL);

  // unit 0 count bytes; a software write in the same cycle wins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      unit0_low_byte  <= `DTC_RST_BYTE;
      unit0_high_byte <= `DTC_RST_BYTE;
    end else begin
      if (ev0) begin
        unit0_low_byte  <= nxt0[7:0];
        unit0_high_byte <= nxt0[15:8];
      end
      if (hi0_ev) begin
        unit0_high_byte <= 8'(unit0_high_byte + 8'h01);
      end
      if (reg_wr && reg_addr == `DTC_OFS_U0_LO) begin
        unit0_low_byte <= reg_wdata;
      end
      if (reg_wr && reg_addr == `DTC_OFS_U0_HI) begin
        unit0_high_byte <= reg_wdata;
      end
    end
  end

  // unit 1 count bytes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      unit1_low_byte  <= `DTC_RST_BYTE;
      unit1_high_byte <= `DTC_RST_BYTE;
    end else begin
      if (ev1) begin
        unit1_low_byte  <= nxt1[7:0];
        unit1_high_byte <= nxt1[15:8];
      end
      if (reg_wr && reg_addr == `DTC_OFS_U1_LO) begin
        unit1_low_byte <= reg_wdata;
      end
      if (reg_wr && reg_addr == `DTC_OFS_U1_HI) begin
        unit1_high_byte <= reg_wdata;
      end
    end
  end

  // overflow flags: hardware set beats software or vector clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      unit0_overflow_flag <= `DTC_RST_BIT;
    end else if (ovf0) begin
      unit0_overflow_flag <= 1'b1;
    end else if (wr_ctrl) begin
      unit0_overflow_flag <= reg_wdata[`DTC_FLAG0_BIT];
    end else if (unit0_vector_ack) begin
      unit0_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      unit1_overflow_flag <= `DTC_RST_BIT;
    end else if (split0 ? ovf_hi0 : ovf1) begin
      unit1_overflow_flag <= 1'b1;
    end else if (wr_ctrl) begin
      unit1_overflow_flag <= reg_wdata[`DTC_FLAG1_BIT];
    end else if (unit1_vector_ack) begin
      unit1_overflow_flag <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_mode_reg  <= `DTC_RST_BYTE;
      unit0_run_bit   <= `DTC_RST_BIT;
      unit1_run_bit   <= `DTC_RST_BIT;
      unit0_speed_sel <= `DTC_RST_BIT;
      unit1_speed_sel <= `DTC_RST_BIT;
    end else if (reg_wr) begin
      if (reg_addr == `DTC_OFS_MODE) begin
        timer_mode_reg <= reg_wdata;
      end
      if (reg_addr == `DTC_OFS_CTRL) begin
        unit0_run_bit <= reg_wdata[`DTC_RUN0_BIT];
        unit1_run_bit <= reg_wdata[`DTC_RUN1_BIT];
      end
      if (reg_addr == `DTC_OFS_CLK) begin
        unit0_speed_sel <= reg_wdata[`DTC_SPD0_BIT];
        unit1_speed_sel <= reg_wdata[`DTC_SPD1_BIT];
      end
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        `DTC_OFS_MODE:  reg_rdata <= timer_mode_reg;
        `DTC_OFS_CTRL:  reg_rdata <= {unit1_overflow_flag, unit1_run_bit,
                                      unit0_overflow_flag, unit0_run_bit, 4'h0};
        `DTC_OFS_CLK:   reg_rdata <= {3'h0, unit1_speed_sel, unit0_speed_sel, 3'h0};
        `DTC_OFS_U0_LO: reg_rdata <= unit0_low_byte;
        `DTC_OFS_U0_HI: reg_rdata <= unit0_high_byte;
        `DTC_OFS_U1_LO: reg_rdata <= unit1_low_byte;
        `DTC_OFS_U1_HI: reg_rdata <= unit1_high_byte;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic [15:0] cnt0;
  logic [15:0] cnt1;
  assign cnt0 = {unit0_high_byte, unit0_low_byte};
  assign cnt1 = {unit1_high_byte, unit1_low_byte};

  sequence s_fall_a;
    phase == PH_C4 && smp_a && !lvl_a;
  endsequence

  sequence s_edge_counting;
    s_fall_a ##0 (ct0 && run0_ok && mode0 == MODE_16 && !reg_wr) [*4];
  endsequence

  property p_cnt_edge;
    s_edge_counting |=> cnt0 == 16'($past(cnt0, 4) + 16'h0001);
  endproperty
  a_cnt_edge: assert property (p_cnt_edge) else $error("edge not counted at next C3");

  property p_upd_c3;
    ($changed(cnt0) && !$past(reg_wr)) |-> $past(phase) == PH_C3;
  endproperty
  a_upd_c3: assert property (p_upd_c3) else $error("count changed outside C3");

  property p_edge_c4;
    $rose(pend_a) |-> $past(phase) == PH_C4 && $past(smp_a) && !$past(lvl_a);
  endproperty
  a_edge_c4: assert property (p_edge_c4) else $error("edge taken outside C4 sample");

  property p_tick12;
    (ev0 && !ct0 && !unit0_speed_sel) |=> (!ev0 || unit0_speed_sel || ct0) [*8];
  endproperty
  a_tick12: assert property (p_tick12) else $error("slow rate ticks too often");

  property p_wrap13;
    (ev0 && mode0 == MODE_13 && {unit0_high_byte, unit0_low_byte[4:0]} == 13'h1FFF && !reg_wr)
      |=> unit0_overflow_flag && unit0_high_byte == 8'h00 && unit0_low_byte[4:0] == 5'h00;
  endproperty
  a_wrap13: assert property (p_wrap13) else $error("13-bit wrap wrong");

  property p_reload;
    (ev0 && mode0 == MODE_RELOAD && unit0_low_byte == 8'hFF && !reg_wr)
      |=> unit0_low_byte == $past(unit0_high_byte) && $stable(unit0_high_byte)
          && unit0_overflow_flag;
  endproperty
  a_reload: assert property (p_reload) else $error("auto-reload wrong");

  property p_freeze1;
    (frozen1 && !reg_wr) |=> $stable(cnt1);
  endproperty
  a_freeze1: assert property (p_freeze1) else $error("unit 1 moved while frozen");

  property p_hold0;
    (!run0_ok && !split0 && !reg_wr) |=> $stable(cnt0) && !$rose(unit0_overflow_flag);
  endproperty
  a_hold0: assert property (p_hold0) else $error("disabled unit 0 changed");

  property p_ack0;
    (unit0_vector_ack && !ovf0 && !wr_ctrl) |=> !unit0_overflow_flag;
  endproperty
  a_ack0: assert property (p_ack0) else $error("flag not cleared on vector");

  property p_split_hi;
    (hi0_ev && unit0_high_byte == 8'hFF && !reg_wr)
      |=> unit1_overflow_flag && unit0_high_byte == 8'h00;
  endproperty
  a_split_hi: assert property (p_split_hi) else $error("split high byte wrap wrong");

  property p_t1_noflag;
    (split0 && !ovf_hi0 && !wr_ctrl) |=> !$rose(unit1_overflow_flag);
  endproperty
  a_t1_noflag: assert property (p_t1_noflag) else $error("unit 1 flagged under split");

endmodule

// *** dual_timer_counter_four_mode_bench.sv ***
`timescale 1ns/10ps
`include "dtc_cfg.svh"
module dual_timer_counter_four_mode_bench;
  import dtc_pkg::*;
  localparam int LIMIT = 20000;
  logic      mclk;
  logic      sys_rst;
  dtc_addr_t reg_addr;
  dtc_byte_t reg_wdata;
  dtc_byte_t reg_rdata;
  logic      reg_wr;
  logic      reg_rd;
  logic      count_input_a;
  logic      count_input_b;
  logic      ext_irq_pin_a;
  logic      ext_irq_pin_b;
  logic      unit0_vector_ack;
  logic      unit1_vector_ack;
  logic      unit0_overflow_flag;
  logic      unit1_overflow_flag;
  int        miscompares;
  int        tests_run;
  int        cycles;
  dtc_byte_t rv;
  dtc_byte_t rv2;

  dtc_timer_pair dtc_timer_pair_inst (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_input_a(count_input_a), .count_input_b(count_input_b),
    .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b),
    .unit0_vector_ack(unit0_vector_ack), .unit1_vector_ack(unit1_vector_ack),
    .unit0_overflow_flag(unit0_overflow_flag), .unit1_overflow_flag(unit1_overflow_flag)
  );

  dtc_pulse_src dtc_pulse_src_inst (
    .mclk(mclk), .count_input_a(count_input_a), .count_input_b(count_input_b),
    .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b)
  );

  always #2 mclk = ~mclk;

  task automatic results();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      $display("[FAIL] %0t run did not finish in time", $time);
      results();
    end
  end

  task automatic wr(input dtc_addr_t a, input dtc_byte_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  // data stands only in the cycle after the taking edge
  task automatic rd(input dtc_addr_t a, output dtc_byte_t d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
    @(posedge mclk);
  endtask

  task automatic chk(input dtc_byte_t got, input dtc_byte_t exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic rchk(input dtc_addr_t a, input dtc_byte_t exp, input string what);
    dtc_byte_t d;
    rd(a, d);
    chk(d, exp, what);
  endtask

  // polls the flag between edges, returns on the next rising edge
  task automatic wait_flag(input logic unit);
    int n;
    n = 0;
    @(negedge mclk);
    while ((unit ? unit1_overflow_flag : unit0_overflow_flag) !== 1'b1 && n < 200) begin
      n++;
      @(negedge mclk);
    end
    chk_bit(n < 200, 1'b1, "flag wait");
    @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    unit0_vector_ack = 1'b0;
    unit1_vector_ack = 1'b0;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    // reset values, unmapped place, direct byte access
    for (int a = 0; a < 8; a++) begin
      rchk(dtc_addr_t'(a), 8'h00, "reset value");
    end
    wr(3'h7, 8'hA5);
    rchk(3'h7, 8'h00, "unmapped");
    wr(`DTC_OFS_U0_LO, 8'h5A);
    wr(`DTC_OFS_U0_HI, 8'hA5);
    rchk(`DTC_OFS_U0_LO, 8'h5A, "low byte");
    rchk(`DTC_OFS_U0_HI, 8'hA5, "high byte");
    $display("test registers done");
    // tick rate over exactly 120 clocks of run
    for (int s = 0; s < 2; s++) begin
      wr(`DTC_OFS_U0_LO, 8'h00);
      wr(`DTC_OFS_U0_HI, 8'h00);
      wr(`DTC_OFS_MODE, 8'h01);
      wr(`DTC_OFS_CLK, s ? 8'h08 : 8'h00);
      wr(`DTC_OFS_CTRL, 8'h10);
      repeat (118) @(posedge mclk);
      wr(`DTC_OFS_CTRL, 8'h00);
      rchk(`DTC_OFS_U0_LO, s ? 8'h1E : 8'h0A, "tick count");
    end
    $display("test rates done");
    // 13-bit wrap keeps low byte upper bits
    wr(`DTC_OFS_MODE, 8'h00);
    wr(`DTC_OFS_CLK, 8'h08);
    wr(`DTC_OFS_U0_HI, 8'hFF);
    wr(`DTC_OFS_U0_LO, 8'hFF);
    wr(`DTC_OFS_CTRL, 8'h10);
    wait_flag(1'b0);
    rchk(`DTC_OFS_U0_LO, 8'hE0, "13-bit low");
    rchk(`DTC_OFS_U0_HI, 8'h00, "13-bit high");
    chk_bit(unit1_overflow_flag, 1'b0, "other flag");
    unit0_vector_ack <= 1'b1;
    @(posedge mclk);
    unit0_vector_ack <= 1'b0;
    @(negedge mclk);
    chk_bit(unit0_overflow_flag, 1'b0, "vector clear 0");
    @(posedge mclk);
    wr(`DTC_OFS_CTRL, 8'h00);
    $display("test mode 0 done");
    // auto reload on unit 1, then hold and vector clear
    wr(`DTC_OFS_MODE, 8'h20);
    rchk(`DTC_OFS_MODE, 8'h20, "mode readback");
    wr(`DTC_OFS_CLK, 8'h10);
    rchk(`DTC_OFS_CLK, 8'h10, "speed readback");
    wr(`DTC_OFS_U1_HI, 8'hF0);
    wr(`DTC_OFS_U1_LO, 8'hFE);
    wr(`DTC_OFS_CTRL, 8'h40);
    wait_flag(1'b1);
    rchk(`DTC_OFS_U1_LO, 8'hF0, "reload low");
    rchk(`DTC_OFS_U1_HI, 8'hF0, "reload high");
    wr(`DTC_OFS_CTRL, 8'h80);
    rchk(`DTC_OFS_CTRL, 8'h80, "ctrl readback");
    rd(`DTC_OFS_U1_LO, rv);
    repeat (40) @(posedge mclk);
    rchk(`DTC_OFS_U1_LO, rv, "stopped holds");
    chk_bit(unit1_overflow_flag, 1'b1, "flag stands");
    unit1_vector_ack <= 1'b1;
    @(posedge mclk);
    unit1_vector_ack <= 1'b0;
    @(negedge mclk);
    chk_bit(unit1_overflow_flag, 1'b0, "vector clear");
    @(posedge mclk);
    $display("test mode 2 done");
    // external edges with gate qualification
    wr(`DTC_OFS_MODE, 8'h0D);
    wr(`DTC_OFS_U0_LO, 8'h00);
    wr(`DTC_OFS_U0_HI, 8'h00);
    wr(`DTC_OFS_CTRL, 8'h10);
    dtc_pulse_src_inst.gate(1'b0, 1'b0);
    dtc_pulse_src_inst.pulses(1'b0, 2, 8);
    repeat (20) @(posedge mclk);
    rchk(`DTC_OFS_U0_LO, 8'h00, "gated off");
    dtc_pulse_src_inst.gate(1'b0, 1'b1);
    repeat (8) @(posedge mclk);
    dtc_pulse_src_inst.pulses(1'b0, 3, 4);
    repeat (20) @(posedge mclk);
    rchk(`DTC_OFS_U0_LO, 8'h03, "edge count");
    wr(`DTC_OFS_CTRL, 8'h00);
    $display("test counter done");
    // split mode: high byte uses unit 1 run and flag
    wr(`DTC_OFS_MODE, 8'h13);
    wr(`DTC_OFS_CLK, 8'h08);
    wr(`DTC_OFS_U0_LO, 8'h00);
    wr(`DTC_OFS_U0_HI, 8'hFE);
    wr(`DTC_OFS_U1_LO, 8'h00);
    wr(`DTC_OFS_CTRL, 8'h40);
    wait_flag(1'b1);
    chk_bit(unit0_overflow_flag, 1'b0, "split low flag");
    rchk(`DTC_OFS_U0_HI, 8'h00, "split high");
    rchk(`DTC_OFS_U0_LO, 8'h00, "split low stopped");
    wr(`DTC_OFS_CTRL, 8'h00);
    rd(`DTC_OFS_U1_LO, rv);
    repeat (22) @(posedge mclk);
    rd(`DTC_OFS_U1_LO, rv2);
    chk(rv2, rv + 8'h02, "unit 1 ticks");
    chk_bit(unit1_overflow_flag, 1'b0, "unit 1 no flag");
    $display("test split done");
    // unit 1 in mode 3 is frozen
    wr(`DTC_OFS_MODE, 8'h31);
    wr(`DTC_OFS_U1_LO, 8'h55);
    wr(`DTC_OFS_CTRL, 8'h40);
    repeat (40) @(posedge mclk);
    rchk(`DTC_OFS_U1_LO, 8'h55, "frozen");
    wr(`DTC_OFS_CTRL, 8'h00);
    $display("test freeze done");
    // unit 1 external edges qualified by its own gate pin
    wr(`DTC_OFS_MODE, 8'hD0);
    wr(`DTC_OFS_U1_LO, 8'h00);
    wr(`DTC_OFS_CTRL, 8'h40);
    dtc_pulse_src_inst.gate(1'b1, 1'b0);
    dtc_pulse_src_inst.pulses(1'b1, 2, 4);
    repeat (20) @(posedge mclk);
    rchk(`DTC_OFS_U1_LO, 8'h00, "unit 1 gated off");
    dtc_pulse_src_inst.gate(1'b1, 1'b1);
    repeat (8) @(posedge mclk);
    dtc_pulse_src_inst.pulses(1'b1, 2, 4);
    repeat (20) @(posedge mclk);
    rchk(`DTC_OFS_U1_LO, 8'h02, "unit 1 edge count");
    wr(`DTC_OFS_CTRL, 8'h00);
    $display("test unit 1 counter done");
    results();
  end
endmodule
